// File: rtl/prog_port.sv
// Parallel programming port: command/address/data loading, page buffers,
// fuse and lock bits, and a request stream toward the memory array.
// Assumes the memory side consumes MEM_REQ, pulses MEM_DONE after a
// request marked last, and returns read words with MEM_RVALID.
//
// Contract
// - Load clock rise: action 00 address, 01 data, 10 command, 11 nothing.
// - Write strobe or output enable low performs the last loaded command.
// - Command byte encodings for erase, writes and reads are fixed.
// - Ready/busy low during programming or erase, high when commands accepted; fuse and lock writes here never take it low.
// - Byte select one and two choose low, high or second high byte.
// - Data bus driven only while output enable is low.
// - Entry pins changing within 100ns of high voltage cancel entry.
// - Command and address stay loaded across programming.
// - Chip erase clears flash, SRAM, EEPROM, then locks; fuses kept.
// - Keep-EEPROM fuse programmed leaves EEPROM intact on chip erase.
// - Chip erase starts on write strobe; busy until done.
// - Flash write: command, address low, data low, data high, latch, program.
// - Page latch rise with byte select one high stores word in buffer.
// - Flash page 64 words; word bits 5:0, page bits 13:6.
// - EEPROM page 4 bytes; byte bits 1:0, page bits 9:2.
// - Upper address low bits act as page bits during page write.
// - Write strobe with byte select one low programs buffered page.
// - Trim register loads the first calibration byte at reset.
// - Signature bytes always readable, locked or not.
// - Command 0000 0000 is no operation ending page programming.
// - Read flash: byte select one low gives low byte, high gives high.

`timescale 1ns/1ns
`default_nettype none

module prog_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;

  assign in_ready  = (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]) || (wptr_reg[AW] == rptr_reg[AW]);
  assign out_valid = (wptr_reg != rptr_reg);
  assign out_data  = store[rptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      store[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule

module prog_port
  import prog_port_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        LOAD_CLOCK_PIN,
  input  wire logic        ACTION_CODE_BIT0,
  input  wire logic        ACTION_CODE_BIT1,
  input  wire logic        BYTE_SELECT_ONE,
  input  wire logic        BYTE_SELECT_TWO,
  input  wire logic        PAGE_BUFFER_LATCH,
  input  wire logic        WRITE_N,
  input  wire logic        OUTPUT_ENABLE_N,
  input  wire logic        HIGH_VOLTAGE_RESET,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE_N,
  output logic             READY_NOT_BUSY,
  output logic             PROG_MODE,
  output logic      [7:0]  RC_TRIM_REGISTER,
  output logic             KEEP_EEPROM_ON_ERASE,
  output mem_req_s         MEM_REQ,
  output logic             MEM_VALID,
  input  wire logic        MEM_READY,
  input  wire logic        MEM_DONE,
  input  wire logic [15:0] MEM_RDATA,
  input  wire logic        MEM_RVALID
);

  logic [NUM_SYNC-1:0] raw;
  logic [NUM_SYNC-1:0] s1_reg;
  logic [NUM_SYNC-1:0] s2_reg;
  logic [NUM_SYNC-1:0] s3_reg;
  logic [NUM_SYNC-1:0] filt_reg;
  logic [NUM_SYNC-1:0] prev_reg;

  assign raw = {DATA_IN, LOAD_CLOCK_PIN, ACTION_CODE_BIT1, ACTION_CODE_BIT0, BYTE_SELECT_ONE,
                BYTE_SELECT_TWO, PAGE_BUFFER_LATCH, WRITE_N, OUTPUT_ENABLE_N, HIGH_VOLTAGE_RESET};

  // Three stages per pin; a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYNC; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (RESET) begin
          s1_reg[gi]   <= PIN_RESET[gi];
          s2_reg[gi]   <= PIN_RESET[gi];
          s3_reg[gi]   <= PIN_RESET[gi];
          filt_reg[gi] <= PIN_RESET[gi];
          prev_reg[gi] <= PIN_RESET[gi];
        end else begin
          s1_reg[gi]   <= raw[gi];
          s2_reg[gi]   <= s1_reg[gi];
          s3_reg[gi]   <= s2_reg[gi];
          prev_reg[gi] <= filt_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  logic       hv;
  logic       oe_n;
  logic       bs1;
  logic       bs2;
  logic [1:0] act;
  logic [7:0] din;
  logic       lclk_rise;
  logic       page_buffer_latch_rise;
  logic       wr_fall;
  logic       oe_fall;
  logic       hv_rise;
  logic [3:0] entry_pins;
  logic [3:0] entry_prev;

  assign hv         = filt_reg[PIN_HV];
  assign oe_n       = filt_reg[PIN_OE_N];
  assign bs1        = filt_reg[PIN_BS1];
  assign bs2        = filt_reg[PIN_BS2];
  assign act        = {filt_reg[PIN_ACT1], filt_reg[PIN_ACT0]};
  assign din        = filt_reg[PIN_DATA +: 8];
  assign lclk_rise  = filt_reg[PIN_LCLK] && !prev_reg[PIN_LCLK];
  assign page_buffer_latch_rise = filt_reg[PIN_PAGE_BUFFER_LATCH] && !prev_reg[PIN_PAGE_BUFFER_LATCH];
  assign wr_fall    = !filt_reg[PIN_WR_N] && prev_reg[PIN_WR_N];
  assign oe_fall    = !oe_n && prev_reg[PIN_OE_N];
  assign hv_rise    = hv && !prev_reg[PIN_HV];
  assign entry_pins = {filt_reg[PIN_PAGE_BUFFER_LATCH], act, bs1};
  assign entry_prev = {prev_reg[PIN_PAGE_BUFFER_LATCH], prev_reg[PIN_ACT1], prev_reg[PIN_ACT0],
                       prev_reg[PIN_BS1]};

  // Entry into programming mode
  logic       prog_mode_reg;
  logic       entry_arm_reg;
  logic [1:0] entry_cnt_reg;

  always_ff @(posedge CLK) begin
    if (RESET || !hv) begin
      prog_mode_reg <= 1'b0;
      entry_arm_reg <= 1'b0;
      entry_cnt_reg <= 2'h0;
    end else if (hv_rise) begin
      entry_arm_reg <= (entry_pins == 4'h0);
      entry_cnt_reg <= 2'h0;
    end else if (entry_arm_reg) begin
      // Pins moving inside hold cancel entry
      if (entry_pins != entry_prev) begin
        entry_arm_reg <= 1'b0;
      end else if (entry_cnt_reg == 2'(ENTRY_HOLD_CYC - 1)) begin
        prog_mode_reg <= 1'b1;
        entry_arm_reg <= 1'b0;
      end else begin
        entry_cnt_reg <= entry_cnt_reg + 2'h1;
      end
    end
  end

  // Command, address and data latches
  logic [7:0] cmd_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] data_lo_reg;
  logic [7:0] data_hi_reg;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cmd_reg     <= CMD_NOP;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      data_lo_reg <= 8'h00;
      data_hi_reg <= 8'h00;
    end else if (prog_mode_reg && lclk_rise) begin
      // Byte select one picks the byte
      // Loading no-op command is plain command load
      unique case (act)
        ACT_ADDR: begin
          if (bs1) begin
            addr_hi_reg <= din;
          end else begin
            addr_lo_reg <= din;
          end
        end
        ACT_DATA: begin
          if (bs1) begin
            data_hi_reg <= din;
          end else begin
            data_lo_reg <= din;
          end
        end
        ACT_CMD: begin
          cmd_reg <= din;
        end
        default: begin
        end
      endcase
    end
  end

  // Page buffers
  logic [15:0] page_buf [FLASH_PAGE_WORDS];
  logic [7:0]  ee_buf   [EE_PAGE_BYTES];

  always_ff @(posedge CLK) begin
    if (prog_mode_reg && page_buffer_latch_rise) begin
      if (cmd_reg == CMD_WR_FLASH && bs1) begin
        page_buf[addr_lo_reg[FLASH_WORD_BITS-1:0]] <= {data_hi_reg, data_lo_reg};
      end
      if (cmd_reg == CMD_WR_EE) begin
        ee_buf[addr_lo_reg[EE_BYTE_BITS-1:0]] <= data_lo_reg;
      end
    end
  end

  // Sequencer
  prog_state_e state_reg;
  logic [6:0]  idx_reg;
  logic        is_flash_reg;
  logic        is_erase_reg;
  logic        rd_pend_reg;
  logic        push_valid;
  logic        push_ready;
  mem_req_s    push_req;
  logic [7:0]  fuse_lo_reg;
  logic [7:0]  fuse_hi_reg;
  logic [7:0]  lock_reg;
  logic        keep_ee;
  logic        start_wr;
  logic [7:0]  flash_page;
  logic        stream_end;

  assign keep_ee    = !fuse_hi_reg[KEEP_EE_BIT];
  assign start_wr   = prog_mode_reg && wr_fall && (state_reg == ST_IDLE);
  // Upper address low bits become page bits
  assign flash_page = {addr_hi_reg[5:0], addr_lo_reg[7:6]};
  assign stream_end = is_flash_reg ? (idx_reg == 7'(FLASH_PAGE_WORDS))
                                   : (idx_reg == 7'(EE_PAGE_BYTES));

  always_comb begin
    push_valid = 1'b0;
    push_req   = '{op: MEM_RD_FLASH, addr: 14'h0000, data: 16'h0000, last: 1'b0};
    unique case (state_reg)
      ST_STREAM: begin
        push_valid = 1'b1;
        // Word and page fields of flash address
        if (is_flash_reg) begin
          push_req.addr = {flash_page, idx_reg[FLASH_WORD_BITS-1:0]};
          push_req.data = page_buf[idx_reg[FLASH_WORD_BITS-1:0]];
          push_req.op   = stream_end ? MEM_COMMIT_FLASH : MEM_WR_FLASH;
        end else begin
          // Page bits 9:2 of EEPROM address
          push_req.addr = {4'h0, addr_hi_reg[1:0], addr_lo_reg[7:2], idx_reg[1:0]};
          push_req.data = {8'h00, ee_buf[idx_reg[EE_BYTE_BITS-1:0]]};
          push_req.op   = stream_end ? MEM_COMMIT_EE : MEM_WR_EE;
        end
        push_req.last = stream_end;
      end
      ST_ERASE: begin
        push_valid = 1'b1;
        // Flash, SRAM, EEPROM erased in turn
        unique case (idx_reg[1:0])
          2'h0:    push_req.op = MEM_ERASE_FLASH;
          2'h1:    push_req.op = MEM_ERASE_SRAM;
          default: push_req.op = MEM_ERASE_EE;
        endcase
        push_req.last = (idx_reg[1:0] == 2'h2) || (idx_reg[1:0] == 2'h1 && keep_ee);
      end
      ST_IDLE: begin
        push_valid    = rd_pend_reg;
        push_req.op   = (cmd_reg == CMD_RD_EE) ? MEM_RD_EE : MEM_RD_FLASH;
        push_req.addr = (cmd_reg == CMD_RD_EE) ? {4'h0, addr_hi_reg[1:0], addr_lo_reg}
                                               : {addr_hi_reg[5:0], addr_lo_reg};
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET || !prog_mode_reg) begin
      state_reg    <= ST_IDLE;
      idx_reg      <= 7'h00;
      is_flash_reg <= 1'b0;
      is_erase_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          idx_reg <= 7'h00;
          if (start_wr) begin
            if (cmd_reg == CMD_CHIP_ERASE) begin
              state_reg    <= ST_ERASE;
              is_erase_reg <= 1'b1;
            end else if ((cmd_reg == CMD_WR_FLASH || cmd_reg == CMD_WR_EE) && !bs1) begin
              state_reg    <= ST_STREAM;
              is_flash_reg <= (cmd_reg == CMD_WR_FLASH);
              is_erase_reg <= 1'b0;
            end
          end
        end
        ST_STREAM, ST_ERASE: begin
          if (push_ready) begin
            idx_reg <= idx_reg + 7'h01;
            if (push_req.last) begin
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (MEM_DONE) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Fuse and lock bits; erase never touches fuses
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fuse_lo_reg <= FUSE_LO_RESET;
      fuse_hi_reg <= FUSE_HI_RESET;
      lock_reg    <= LOCK_RESET;
    end else if (state_reg == ST_WAIT && MEM_DONE && is_erase_reg) begin
      // Locks cleared only after memory erased
      lock_reg <= LOCK_RESET;
    end else if (start_wr && cmd_reg == CMD_WR_FUSE && !bs2) begin
      if (bs1) begin
        fuse_hi_reg <= data_lo_reg;
      end else begin
        fuse_lo_reg <= data_lo_reg;
      end
    end else if (start_wr && cmd_reg == CMD_WR_LOCK) begin
      // Lock bits can only be programmed; erase is the way back
      lock_reg <= lock_reg & data_lo_reg;
    end
  end

  // Read requests and returned word
  logic [15:0] rd_word_reg;

  always_ff @(posedge CLK) begin
    if (RESET || !prog_mode_reg) begin
      rd_pend_reg <= 1'b0;
      rd_word_reg <= 16'h0000;
    end else begin
      if (oe_fall && (cmd_reg == CMD_RD_FLASH || cmd_reg == CMD_RD_EE)) begin
        rd_pend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && push_ready) begin
        rd_pend_reg <= 1'b0;
      end
      if (MEM_RVALID) begin
        rd_word_reg <= MEM_RDATA;
      end
    end
  end

  // Output byte and bus drive
  logic [7:0] dout_reg;
  logic       drive_n_reg;
  logic [7:0] sig_byte;
  logic [7:0] cal_byte;

  always_comb begin
    unique case (addr_lo_reg[1:0])
      2'h0:    begin sig_byte = SIG_BYTE0; cal_byte = CAL_BYTE0; end
      2'h1:    begin sig_byte = SIG_BYTE1; cal_byte = CAL_BYTE1; end
      2'h2:    begin sig_byte = SIG_BYTE2; cal_byte = CAL_BYTE2; end
      default: begin sig_byte = 8'h00;     cal_byte = CAL_BYTE3; end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      dout_reg    <= 8'h00;
      drive_n_reg <= 1'b1;
    end else begin
      // Bus driven only with output enable low
      drive_n_reg <= !(prog_mode_reg && !oe_n);
      unique case (cmd_reg)
        // Byte select one picks flash byte
        CMD_RD_FLASH: dout_reg <= bs1 ? rd_word_reg[15:8] : rd_word_reg[7:0];
        CMD_RD_EE:    dout_reg <= rd_word_reg[7:0];
        CMD_RD_SIG:   dout_reg <= bs1 ? cal_byte : sig_byte;
        CMD_RD_FUSE: begin
          // Second high byte via byte select two
          unique case ({bs2, bs1})
            2'b00:   dout_reg <= fuse_lo_reg;
            2'b11:   dout_reg <= fuse_hi_reg;
            2'b01:   dout_reg <= lock_reg;
            default: dout_reg <= 8'hFF;
          endcase
        end
        default: dout_reg <= 8'h00;
      endcase
    end
  end

  // Trim register takes the first calibration byte at reset
  logic [7:0] trim_reg;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      trim_reg <= CAL_BYTE0;
    end
  end

  prog_fifo #(
    .WIDTH ($bits(mem_req_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_req),
    .out_valid (MEM_VALID),
    .out_ready (MEM_READY),
    .out_data  (MEM_REQ)
  );

  assign DATA_OUT             = dout_reg;
  assign DATA_OE_N            = drive_n_reg;
  assign READY_NOT_BUSY       = (state_reg == ST_IDLE);
  assign PROG_MODE            = prog_mode_reg;
  assign RC_TRIM_REGISTER     = trim_reg;
  assign KEEP_EEPROM_ON_ERASE = keep_ee;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_load_command: assert property (
      prog_mode_reg && lclk_rise && act == ACT_CMD |=> cmd_reg == $past(din))
    else $error("command byte not loaded");
  a_erase_busy: assert property (
      start_wr && cmd_reg == CMD_CHIP_ERASE |=> !READY_NOT_BUSY [*2])
    else $error("ready stayed high after erase start");
  a_bus_drive: assert property (!DATA_OE_N |-> $past(prog_mode_reg && !oe_n))
    else $error("bus driven without output enable");
  a_page_latch: assert property (
      prog_mode_reg && page_buffer_latch_rise && bs1 && cmd_reg == CMD_WR_FLASH
      |=> page_buf[$past(addr_lo_reg[5:0])] == $past({data_hi_reg, data_lo_reg}))
    else $error("page word not latched");
  a_keep_eeprom: assert property (push_valid && push_req.op == MEM_ERASE_EE |-> !keep_ee)
    else $error("kept EEPROM erased");
  a_lock_clear: assert property (state_reg == ST_WAIT && MEM_DONE && is_erase_reg
      |=> lock_reg == LOCK_RESET && READY_NOT_BUSY)
    else $error("locks not cleared after erase");
  a_flash_page: assert property (push_valid && push_req.op == MEM_WR_FLASH
      |-> push_req.addr[13:6] == {addr_hi_reg[5:0], addr_lo_reg[7:6]})
    else $error("flash page address wrong");
  a_entry_hold: assert property (
      $rose(prog_mode_reg) |-> $past(hv, 3) && entry_pins == 4'h0)
    else $error("entered without stable pins");
  a_ready_idle: assert property (wr_fall && prog_mode_reg && cmd_reg == CMD_NOP
      |=> READY_NOT_BUSY)
    else $error("no-op made device busy");
  a_read_high: assert property (
      prog_mode_reg && cmd_reg == CMD_RD_FLASH && bs1 && !MEM_RVALID
      |=> DATA_OUT == $past(rd_word_reg[15:8]))
    else $error("flash high byte not presented");

endmodule

`default_nettype wire

// File: rtl/prog_port_pkg.sv
// Constants, types and encodings of the parallel programming port.
// Assumes a single 25 MHz clock; pins arrive asynchronously.
package prog_port_pkg;

  localparam int CLK_PERIOD_NS  = 40;
  localparam int ENTRY_HOLD_NS  = 100;
  localparam int ENTRY_HOLD_CYC = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EE      = 8'h11;
  localparam logic [7:0] CMD_RD_SIG     = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EE      = 8'h03;

  localparam int FLASH_PAGE_WORDS = 64;
  localparam int FLASH_WORD_BITS  = 6;
  localparam int FLASH_ADDR_BITS  = 14;
  localparam int EE_PAGE_BYTES    = 4;
  localparam int EE_BYTE_BITS     = 2;

  localparam logic [7:0] FUSE_LO_RESET = 8'hE1;
  localparam logic [7:0] FUSE_HI_RESET = 8'h99;
  localparam logic [7:0] LOCK_RESET    = 8'hFF;
  localparam int         KEEP_EE_BIT   = 3;

  // Arbitrary identity and trim values, not those of any real part
  localparam logic [7:0] SIG_BYTE0 = 8'hA5;
  localparam logic [7:0] SIG_BYTE1 = 8'h5A;
  localparam logic [7:0] SIG_BYTE2 = 8'h3C;
  localparam logic [7:0] CAL_BYTE0 = 8'h80;
  localparam logic [7:0] CAL_BYTE1 = 8'h84;
  localparam logic [7:0] CAL_BYTE2 = 8'h88;
  localparam logic [7:0] CAL_BYTE3 = 8'h8C;

  localparam int FIFO_DEPTH = 8;

  // Synchroniser vector layout
  localparam int NUM_SYNC  = 17;
  localparam int PIN_HV    = 0;
  localparam int PIN_OE_N  = 1;
  localparam int PIN_WR_N  = 2;
  localparam int PIN_PAGE_BUFFER_LATCH = 3;
  localparam int PIN_BS2   = 4;
  localparam int PIN_BS1   = 5;
  localparam int PIN_ACT0  = 6;
  localparam int PIN_ACT1  = 7;
  localparam int PIN_LCLK  = 8;
  localparam int PIN_DATA  = 9;
  localparam logic [NUM_SYNC-1:0] PIN_RESET = 17'h00006;

  typedef enum logic [3:0] {
    MEM_WR_FLASH     = 4'h1,
    MEM_WR_EE        = 4'h2,
    MEM_COMMIT_FLASH = 4'h3,
    MEM_COMMIT_EE    = 4'h4,
    MEM_ERASE_FLASH  = 4'h5,
    MEM_ERASE_SRAM   = 4'h6,
    MEM_ERASE_EE     = 4'h7,
    MEM_RD_FLASH     = 4'h8,
    MEM_RD_EE        = 4'h9
  } mem_op_e;

  typedef struct packed {
    mem_op_e     op;
    logic [13:0] addr;
    logic [15:0] data;
    logic        last;
  } mem_req_s;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_STREAM = 4'b0010,
    ST_ERASE  = 4'b0100,
    ST_WAIT   = 4'b1000
  } prog_state_e;

endpackage

// File: verification/mem_model.sv
// Memory-side partner of the programming port.
// Assumes prog_port_pkg and one clock with synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module mem_model
  import prog_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clr,
  input  wire mem_req_s    req,
  input  wire logic        valid,
  output logic             ready,
  output logic             done,
  output logic      [15:0] rdata,
  output logic             rvalid,
  output logic      [15:0] seen,
  output logic      [7:0]  n_wr,
  output logic      [15:0] word1,
  output logic      [7:0]  pg
);
  logic [1:0]  tick_reg;
  logic [2:0]  done_reg;
  logic [15:0] rd_reg;
  logic        take;
  // Stall one cycle in four so the port sees back-pressure
  assign ready = tick_reg != 2'h3;
  assign take  = valid && ready;
  assign done  = done_reg[2];
  // Read lines show junk outside the answer cycle
  assign rdata = rvalid ? rd_reg : ~rd_reg;
  always_ff @(posedge clk) begin
    tick_reg <= reset ? 2'h0 : tick_reg + 2'h1;
    done_reg <= reset ? 3'h0 : {done_reg[1:0], take & req.last};
    rvalid   <= !reset && take && (req.op == MEM_RD_FLASH || req.op == MEM_RD_EE);
    if (take)
      rd_reg <= {req.addr[7:0], ~req.addr[7:0]};
  end
  always_ff @(posedge clk) begin
    if (reset || clr) begin
      seen <= 16'h0;
      n_wr <= 8'h0;
    end else if (take) begin
      seen[req.op] <= 1'b1;
      if (req.op == MEM_WR_FLASH)
        n_wr <= n_wr + 8'h1;
      if (req.op == MEM_WR_FLASH && req.addr[5:0] == 6'h01) begin
        word1 <= req.data;
        pg    <= req.addr[13:6];
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/prog_port_tb.sv
// Self-checking bench of the programming port.
// Assumes the design files and mem_model; pins driven at falling edges.
`timescale 1ns/1ns
`default_nettype none
module prog_port_tb
  import prog_port_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] adr;
    logic [1:0] bs;
    logic [7:0] exp;
  } row_s;
  logic CLK, RESET, LOAD_CLOCK_PIN, ACTION_CODE_BIT0, ACTION_CODE_BIT1, BYTE_SELECT_ONE;
  logic BYTE_SELECT_TWO, PAGE_BUFFER_LATCH, WRITE_N, OUTPUT_ENABLE_N, HIGH_VOLTAGE_RESET;
  logic DATA_OE_N, READY_NOT_BUSY, PROG_MODE, KEEP_EEPROM_ON_ERASE, MEM_VALID, MEM_READY;
  logic MEM_DONE, MEM_RVALID, mem_clr;
  logic [7:0]  DATA_IN, DATA_OUT, RC_TRIM_REGISTER, n_wr, pg;
  logic [15:0] MEM_RDATA, seen, word1;
  mem_req_s    MEM_REQ;
  int          n_mismatch, tests_run, k;
  row_s rows [13] = '{
    '{CMD_RD_SIG, 8'h00, 2'h0, SIG_BYTE0}, '{CMD_RD_SIG, 8'h01, 2'h0, SIG_BYTE1},
    '{CMD_RD_SIG, 8'h02, 2'h0, SIG_BYTE2}, '{CMD_RD_SIG, 8'h00, 2'h1, CAL_BYTE0},
    '{CMD_RD_SIG, 8'h01, 2'h1, CAL_BYTE1}, '{CMD_RD_SIG, 8'h02, 2'h1, CAL_BYTE2},
    '{CMD_RD_SIG, 8'h03, 2'h1, CAL_BYTE3}, '{CMD_RD_FUSE, 8'h00, 2'h0, FUSE_LO_RESET},
    '{CMD_RD_FUSE, 8'h00, 2'h3, FUSE_HI_RESET}, '{CMD_RD_FUSE, 8'h00, 2'h1, LOCK_RESET},
    '{CMD_RD_FLASH, 8'h12, 2'h0, 8'hED}, '{CMD_RD_FLASH, 8'h12, 2'h1, 8'h12},
    '{CMD_RD_EE, 8'h34, 2'h0, 8'hCB}};

  prog_port u_prog_port (.CLK(CLK), .RESET(RESET), .LOAD_CLOCK_PIN(LOAD_CLOCK_PIN),
    .ACTION_CODE_BIT0(ACTION_CODE_BIT0), .ACTION_CODE_BIT1(ACTION_CODE_BIT1),
    .BYTE_SELECT_ONE(BYTE_SELECT_ONE), .BYTE_SELECT_TWO(BYTE_SELECT_TWO),
    .PAGE_BUFFER_LATCH(PAGE_BUFFER_LATCH), .WRITE_N(WRITE_N),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .HIGH_VOLTAGE_RESET(HIGH_VOLTAGE_RESET),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
    .READY_NOT_BUSY(READY_NOT_BUSY), .PROG_MODE(PROG_MODE),
    .RC_TRIM_REGISTER(RC_TRIM_REGISTER), .KEEP_EEPROM_ON_ERASE(KEEP_EEPROM_ON_ERASE),
    .MEM_REQ(MEM_REQ), .MEM_VALID(MEM_VALID), .MEM_READY(MEM_READY),
    .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID));
  mem_model u_mem_model (.clk(CLK), .reset(RESET), .clr(mem_clr), .req(MEM_REQ),
    .valid(MEM_VALID), .ready(MEM_READY), .done(MEM_DONE), .rdata(MEM_RDATA),
    .rvalid(MEM_RVALID), .seen(seen), .n_wr(n_wr), .word1(word1), .pg(pg));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulses of 8 cycles exceed 250 ns
  task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
    {ACTION_CODE_BIT1, ACTION_CODE_BIT0} = act;
    BYTE_SELECT_ONE = bs;
    DATA_IN = d;
    idle(8);
    LOAD_CLOCK_PIN = 1'b1;
    idle(8);
    LOAD_CLOCK_PIN = 1'b0;
    idle(8);
  endtask
  task automatic wr(input logic bs, input logic bsy);
    logic lo;
    lo = 1'b0;
    mem_clr = 1'b1;
    BYTE_SELECT_ONE = bs;
    idle(1);
    mem_clr = 1'b0;
    idle(7);
    WRITE_N = 1'b0;
    for (k = 0; k < 10; k++) begin
      idle(1);
      if (READY_NOT_BUSY === 1'b0) lo = 1'b1;
    end
    WRITE_N = 1'b1;
    chk(16'(lo), 16'(bsy));
    for (k = 0; k < 3000 && READY_NOT_BUSY !== 1'b1; k++) idle(1);
    chk(16'(READY_NOT_BUSY), 16'h1);
  endtask
  task automatic close_out;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge CLK);
    n_mismatch++;
    close_out();
  end

  initial begin
    {RESET, WRITE_N, OUTPUT_ENABLE_N} = 3'h7;
    {LOAD_CLOCK_PIN, ACTION_CODE_BIT0, ACTION_CODE_BIT1, BYTE_SELECT_ONE} = 4'h0;
    {BYTE_SELECT_TWO, PAGE_BUFFER_LATCH, HIGH_VOLTAGE_RESET, mem_clr} = 4'h0;
    DATA_IN = 8'h00;
    idle(6);
    RESET = 1'b0;
    chk(16'(READY_NOT_BUSY), 16'h1);
    chk(16'(DATA_OE_N), 16'h1);
    chk(16'(RC_TRIM_REGISTER), 16'(CAL_BYTE0));
    repeat (6) load(ACT_ADDR, 1'b0, 8'h00);
    HIGH_VOLTAGE_RESET = 1'b1;
    idle(1);
    BYTE_SELECT_ONE = 1'b1;
    idle(12);
    chk(16'(PROG_MODE), 16'h0);
    {HIGH_VOLTAGE_RESET, BYTE_SELECT_ONE} = 2'h0;
    idle(12);
    HIGH_VOLTAGE_RESET = 1'b1;
    idle(12);
    chk(16'(PROG_MODE), 16'h1);
    foreach (rows[i]) begin
      load(ACT_CMD, 1'b0, rows[i].cmd);
      load(ACT_ADDR, 1'b0, rows[i].adr);
      {BYTE_SELECT_TWO, BYTE_SELECT_ONE} = rows[i].bs;
      OUTPUT_ENABLE_N = 1'b0;
      idle(12);
      chk(16'(DATA_OUT), 16'(rows[i].exp));
      chk(16'(DATA_OE_N), 16'h0);
      OUTPUT_ENABLE_N = 1'b1;
      idle(8);
      chk(16'(DATA_OE_N), 16'h1);
    end
    BYTE_SELECT_TWO = 1'b0;
    load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      load(ACT_ADDR, 1'b0, 8'h40 + 8'(i));
      load(ACT_DATA, 1'b0, 8'h10 + 8'(i));
      load(ACT_DATA, 1'b1, 8'hC0 + 8'(i));
      idle(8);
      PAGE_BUFFER_LATCH = 1'b1;
      idle(8);
      PAGE_BUFFER_LATCH = 1'b0;
      idle(8);
    end
    load(ACT_ADDR, 1'b1, 8'h05);
    wr(1'b0, 1'b1);
    chk(16'(n_wr), 16'd64);
    chk(word1, 16'hC111);
    chk(16'(pg), 16'h15);
    load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    load(ACT_DATA, 1'b0, 8'hFC);
    wr(1'b0, 1'b0);
    load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
    wr(1'b0, 1'b1);
    chk(seen & 16'h00E0, 16'h00E0);
    load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    BYTE_SELECT_ONE = 1'b1;
    OUTPUT_ENABLE_N = 1'b0;
    idle(12);
    chk(16'(DATA_OUT), 16'(LOCK_RESET));
    OUTPUT_ENABLE_N = 1'b1;
    load(ACT_CMD, 1'b0, CMD_WR_FUSE);
    load(ACT_DATA, 1'b0, 8'h91);
    wr(1'b1, 1'b0);
    chk(16'(KEEP_EEPROM_ON_ERASE), 16'h1);
    load(ACT_CMD, 1'b0, CMD_NOP);
    wr(1'b0, 1'b0);
    load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
    wr(1'b0, 1'b1);
    chk(seen & 16'h00E0, 16'h0060);
    // Erased bytes read 0xFF, so only one byte is latched
    load(ACT_CMD, 1'b0, CMD_WR_EE);
    load(ACT_ADDR, 1'b0, 8'h02);
    load(ACT_DATA, 1'b0, 8'h5A);
    PAGE_BUFFER_LATCH = 1'b1;
    idle(8);
    PAGE_BUFFER_LATCH = 1'b0;
    idle(8);
    wr(1'b0, 1'b1);
    chk(seen & 16'h0014, 16'h0014);
    RESET = 1'b1;
    idle(2);
    RESET = 1'b0;
    chk(16'(PROG_MODE), 16'h0);
    chk(16'(READY_NOT_BUSY), 16'h1);
    close_out();
  end
endmodule
`default_nettype wire
